// File: verilog/pe_mux_pkg.sv
package pe_mux_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] ctrl_offset = 12'h000;
   localparam logic [11:0] status_offset = 12'h004;
   localparam logic [15:0] ctrl_reset = 16'h0000;
   localparam logic [15:0] ctrl_mask = 16'h3ffc;
   localparam int npins = 7;
   localparam int pin_base = 8;
   localparam int fld_w = 2;

   // ----------------------------------------
   // Mode codes
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      mode_port = 2'b00,
      mode_timer = 2'b01,
      mode_alt = 2'b10,
      mode_bad = 2'b11
   } pin_mode_e;

   typedef struct packed
   {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } apb_req_s;

   typedef struct packed
   {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

   typedef struct packed
   {
      logic [15:0] ctrl_r;
      logic [6:0] bad_code_r;
      logic [31:0] prdata_r;
      logic pslverr_r;
   } mux_state_s;
endpackage : pe_mux_pkg

// File: verilog/port_e_pin_function_select.sv
// Functional notes
// RQ1: Pin 14 field bits 13:12 picks port I/O on 00 and timer ch4 io c on 01; 10 and 11 invalid.
// RQ2: Pin 13 field bits 11:10 picks port, timer ch4 io b, or manual reset input; 11 invalid.
// RQ3: Pin 12 field bits 9:8 picks port I/O on 00 and timer ch4 io a on 01; others invalid.
// RQ4: Pin 11 field bits 7:6 picks port I/O on 00 and timer ch3 io d on 01; others invalid.
// RQ5: Pin 10 field bits 5:4 picks port, timer ch3 io c, or serial 2 transmit; 11 invalid.
// RQ6: Pin 9 field bits 3:2 picks port I/O on 00 and timer ch3 io b on 01; others invalid.
// RQ7: Software writes only the codes defined for each pin, never a prohibited one.
// RQ8: All fields reset to zero, so every pin starts as port I/O, and all are read/write.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module port_e_pin_function_select
(
   input wire logic mclk,
   input wire logic rst,
   input wire pe_mux_pkg::apb_req_s apb_req,
   output pe_mux_pkg::apb_rsp_s apb_rsp,
   // Pins 14..9 (index 0 = pin 9)
   input wire logic [5:0] port_out,
   input wire logic [5:0] port_oe,
   output logic [5:0] port_in,
   input wire logic [5:0] timer_out,
   input wire logic [5:0] timer_oe,
   output logic [5:0] timer_in,
   input wire logic serial2_transmit,
   output logic manual_reset_in,
   input wire logic [5:0] pad_in,
   output logic [5:0] pad_out,
   output logic [5:0] pad_oe,
   output logic [5:0] pin_mode_invalid
);
   import pe_mux_pkg::*;

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   // Pin p (9..14) owns bits 2*(p-9)+3 : 2*(p-9)+2
   function automatic logic [1:0] field_of(input logic [15:0] c, input int idx);
      field_of = c[idx*fld_w+2 +: fld_w];
   endfunction : field_of

   // Only pins 13 and 10 have a third function
   function automatic logic code_ok(input logic [1:0] m, input int idx);
      code_ok = (m == mode_port) || (m == mode_timer) ||
                ((m == mode_alt) && (idx == 4 || idx == 1));
   endfunction : code_ok

   mux_state_s s_r;
   mux_state_s s_nxt;
   logic [1:0] fld [6];
   logic wr_en;
   logic rd_en;

   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      if (wr_en && apb_req.paddr == ctrl_offset)
      begin
         // Byte strobes honoured; bits above 13 stay zero
         if (apb_req.pstrb[0])
            s_nxt.ctrl_r[7:0] = apb_req.pwdata[7:0] & ctrl_mask[7:0]; // [RQ8]
         if (apb_req.pstrb[1])
            s_nxt.ctrl_r[15:8] = apb_req.pwdata[15:8] & ctrl_mask[15:8]; // [RQ8]
      end
      s_nxt.pslverr_r = 1'b0;
      if (apb_req.psel && !apb_req.penable)
         s_nxt.pslverr_r = (apb_req.paddr != ctrl_offset) &&
                           (apb_req.paddr != status_offset || apb_req.pwrite);
      if (rd_en)
      begin
         if (apb_req.paddr == ctrl_offset)
            s_nxt.prdata_r = {16'h0000, s_r.ctrl_r}; // [RQ8]
         else if (apb_req.paddr == status_offset)
            s_nxt.prdata_r = {25'h0000000, s_r.bad_code_r};
         else
            s_nxt.prdata_r = 32'h0000_0000;
      end
      for (int i = 0; i < 6; i++)
         s_nxt.bad_code_r[i] = !code_ok(field_of(s_nxt.ctrl_r, i), i); // [RQ7]
      s_nxt.bad_code_r[6] = 1'b0;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         s_r <= '{ctrl_r: ctrl_reset, bad_code_r: 7'h00, prdata_r: 32'h0000_0000,
                  pslverr_r: 1'b0}; // [RQ8]
      else
         s_r <= s_nxt;
   end

   assign apb_rsp.prdata = s_r.prdata_r;
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = s_r.pslverr_r && apb_req.psel && apb_req.penable;

   // ----------------------------------------
   // Pin routing
   // ----------------------------------------
   // Invalid codes park the pad as an undriven input; safer than guessing
   for (genvar g = 0; g < 6; g++)
   begin : g_pin
      assign fld[g] = field_of(s_r.ctrl_r, g);
      always_comb
      begin
         pad_out[g] = 1'b0;
         pad_oe[g] = 1'b0;
         port_in[g] = 1'b0;
         timer_in[g] = 1'b0;
         case (fld[g])
            mode_port:
            begin
               pad_out[g] = port_out[g];
               pad_oe[g] = port_oe[g];
               port_in[g] = pad_in[g];
            end
            mode_timer:
            begin
               pad_out[g] = timer_out[g]; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6]
               pad_oe[g] = timer_oe[g];
               timer_in[g] = pad_in[g];
            end
            mode_alt:
            begin
               if (g == 1)
               begin
                  pad_out[g] = serial2_transmit; // [RQ5]
                  pad_oe[g] = 1'b1;
               end
            end
            default:
            begin
               pad_oe[g] = 1'b0;
            end
         endcase
      end
   end

   // Idle high when not routed, matching an inactive low-true reset request
   assign manual_reset_in = (fld[4] == mode_alt) ? pad_in[4] : 1'b1; // [RQ2]
   assign pin_mode_invalid = s_r.bad_code_r[5:0]; // [RQ7]

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_reset_zero: assert property (@(posedge mclk) $rose(rst) |=> s_r.ctrl_r == 16'h0000 || rst) // [RQ8]
      else $error("control not zero after reset");
   chk_pin14_timer: assert property (@(posedge mclk) disable iff (rst)
      s_r.ctrl_r[13:12] == 2'b01 |-> pad_out[5] == timer_out[5] && pad_oe[5] == timer_oe[5]) // [RQ1]
      else $error("pin14 timer route wrong");
   chk_pin13_manual_reset_in: assert property (@(posedge mclk) disable iff (rst)
      s_r.ctrl_r[11:10] == 2'b10 |-> manual_reset_in == pad_in[4] && !pad_oe[4]) // [RQ2]
      else $error("pin13 manual reset route wrong");
   chk_pin12_timer: assert property (@(posedge mclk) disable iff (rst)
      s_r.ctrl_r[9:8] == 2'b01 |-> timer_in[3] == pad_in[3]) // [RQ3]
      else $error("pin12 timer input wrong");
   chk_pin11_port: assert property (@(posedge mclk) disable iff (rst)
      s_r.ctrl_r[7:6] == 2'b00 |-> port_in[2] == pad_in[2] && pad_out[2] == port_out[2]) // [RQ4]
      else $error("pin11 port route wrong");
   chk_pin10_serial: assert property (@(posedge mclk) disable iff (rst)
      s_r.ctrl_r[5:4] == 2'b10 |-> pad_oe[1] && pad_out[1] == serial2_transmit) // [RQ5]
      else $error("pin10 serial route wrong");
   chk_pin9_timer: assert property (@(posedge mclk) disable iff (rst)
      s_r.ctrl_r[3:2] == 2'b01 |-> pad_out[0] == timer_out[0]) // [RQ6]
      else $error("pin9 timer route wrong");
   chk_bad_flag: assert property (@(posedge mclk) disable iff (rst)
      s_r.ctrl_r[13:12] == 2'b11 |-> pin_mode_invalid[5] && !pad_oe[5]) // [RQ7]
      else $error("prohibited code not flagged");
   chk_write_read: assert property (@(posedge mclk) disable iff (rst)
      wr_en && apb_req.paddr == ctrl_offset && apb_req.pstrb == 4'hf
      |=> s_r.ctrl_r == ($past(apb_req.pwdata[15:0]) & ctrl_mask)) // [RQ8]
      else $error("control write lost");

   // ----------------------------------------
   // Per-pin checks
   // ----------------------------------------
   chk_p9_port: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
      fld[0] == mode_port |-> pad_oe[0] == port_oe[0] && port_in[0] == pad_in[0])
      else $error("pin9 port route wrong");

   chk_p9_timer: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
      fld[0] == mode_timer |-> pad_oe[0] == timer_oe[0] && timer_in[0] == pad_in[0])
      else $error("pin9 timer oe wrong");

   chk_p9_alt_bad: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
      fld[0] == mode_alt |-> pin_mode_invalid[0] && !pad_oe[0] && !port_in[0] && !timer_in[0])
      else $error("pin9 code 10 not parked");

   chk_p9_bad: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
      fld[0] == mode_bad |-> pin_mode_invalid[0] && !pad_oe[0])
      else $error("pin9 code 11 not parked");

   chk_p10_port: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
      fld[1] == mode_port |-> pad_oe[1] == port_oe[1] && port_in[1] == pad_in[1])
      else $error("pin10 port route wrong");

   chk_p10_timer: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
      fld[1] == mode_timer |-> pad_oe[1] == timer_oe[1] && timer_in[1] == pad_in[1])
      else $error("pin10 timer route wrong");

   chk_p10_bad: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
      fld[1] == mode_bad |-> pin_mode_invalid[1] && !pad_oe[1])
      else $error("pin10 code 11 not parked");

   chk_p10_alt_ok: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
      fld[1] == mode_alt |-> !pin_mode_invalid[1])
      else $error("pin10 serial code flagged");

   chk_p10_alt_in: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
      fld[1] == mode_alt |-> !port_in[1] && !timer_in[1])
      else $error("pin10 serial leaks input");

   chk_p11_port: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
      fld[2] == mode_port |-> pad_oe[2] == port_oe[2])
      else $error("pin11 port oe wrong");

   chk_p11_timer: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
      fld[2] == mode_timer |-> pad_out[2] == timer_out[2] && timer_in[2] == pad_in[2])
      else $error("pin11 timer route wrong");

   chk_p11_alt_bad: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
      fld[2] == mode_alt |-> pin_mode_invalid[2] && !pad_oe[2])
      else $error("pin11 code 10 not parked");

   chk_p11_bad: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
      fld[2] == mode_bad |-> pin_mode_invalid[2] && !pad_oe[2])
      else $error("pin11 code 11 not parked");

   chk_p12_port: assert property (@(posedge mclk) disable iff (rst) // [RQ3]
      fld[3] == mode_port |-> pad_oe[3] == port_oe[3] && port_in[3] == pad_in[3])
      else $error("pin12 port route wrong");

   chk_p12_timer: assert property (@(posedge mclk) disable iff (rst) // [RQ3]
      fld[3] == mode_timer |-> pad_oe[3] == timer_oe[3] && pad_out[3] == timer_out[3])
      else $error("pin12 timer drive wrong");

   chk_p12_alt_bad: assert property (@(posedge mclk) disable iff (rst) // [RQ3]
      fld[3] == mode_alt |-> pin_mode_invalid[3] && !pad_oe[3])
      else $error("pin12 code 10 not parked");

   chk_p12_bad: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
      fld[3] == mode_bad |-> pin_mode_invalid[3] && !pad_oe[3])
      else $error("pin12 code 11 not parked");

   chk_p13_port: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
      fld[4] == mode_port |-> pad_oe[4] == port_oe[4] && port_in[4] == pad_in[4])
      else $error("pin13 port route wrong");

   chk_p13_timer: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
      fld[4] == mode_timer |-> pad_oe[4] == timer_oe[4] && timer_in[4] == pad_in[4])
      else $error("pin13 timer route wrong");

   chk_p13_alt_ok: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
      fld[4] == mode_alt |-> !pin_mode_invalid[4] && !port_in[4] && !timer_in[4])
      else $error("pin13 reset code mishandled");

   chk_p13_bad: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
      fld[4] == mode_bad |-> pin_mode_invalid[4] && !pad_oe[4])
      else $error("pin13 code 11 not parked");

   chk_manual_reset_in_idle: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
      fld[4] != mode_alt |-> manual_reset_in)
      else $error("manual reset not idle");

   chk_p14_port: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
      fld[5] == mode_port |-> pad_oe[5] == port_oe[5] && port_in[5] == pad_in[5])
      else $error("pin14 port route wrong");

   chk_p14_timer_in: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
      fld[5] == mode_timer |-> timer_in[5] == pad_in[5] && !port_in[5])
      else $error("pin14 timer input wrong");

   chk_p14_alt_bad: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
      fld[5] == mode_alt |-> pin_mode_invalid[5] && !pad_oe[5])
      else $error("pin14 code 10 not parked");

   // ----------------------------------------
   // Bus checks
   // ----------------------------------------
   chk_bus_ready: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
      apb_req.psel |-> apb_rsp.pready)
      else $error("ready dropped");

   chk_err_access: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
      !(apb_req.psel && apb_req.penable) |-> !apb_rsp.pslverr)
      else $error("error outside access");

   chk_unused_bits: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
      s_r.ctrl_r[15:14] == 2'b00 && s_r.ctrl_r[1:0] == 2'b00)
      else $error("unused control bits set");

   chk_ctrl_read: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
      rd_en && apb_req.paddr == ctrl_offset |=> apb_rsp.prdata == {16'h0000, $past(s_r.ctrl_r)})
      else $error("control read wrong");

   chk_status_read: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
      rd_en && apb_req.paddr == status_offset
      |=> apb_rsp.prdata == {25'h0000000, $past(s_r.bad_code_r)})
      else $error("status read wrong");

   cov_timer: cover property (@(posedge mclk) s_r.ctrl_r[13:12] == 2'b01);
   cov_manual_reset_in: cover property (@(posedge mclk) s_r.ctrl_r[11:10] == 2'b10);
   cov_serial: cover property (@(posedge mclk) s_r.ctrl_r[5:4] == 2'b10);
   cov_bad: cover property (@(posedge mclk) |pin_mode_invalid);
endmodule : port_e_pin_function_select
`default_nettype wire

// File: dv/pin_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ----------
// Pads and peripherals
// ----------
module pin_partner
(
   input wire logic mclk,
   output logic [5:0] pad_in,
   output logic [5:0] port_out,
   output logic [5:0] port_oe,
   output logic [5:0] timer_out,
   output logic [5:0] timer_oe,
   output logic serial2_transmit
);
   // Fresh random values every cycle, so stale routing matches any one bit only by chance
   initial
   begin
      {pad_in, port_out, port_oe, timer_out, timer_oe, serial2_transmit} = '0;
   end
   always @(posedge mclk)
   begin
      {pad_in, port_out, port_oe, timer_out, timer_oe} <= 30'($urandom);
      serial2_transmit <= 1'($urandom);
   end
endmodule : pin_partner
`default_nettype wire

// File: dv/tb_port_e_pin_function_select.sv
`timescale 1ns/100ps
`default_nettype none
module tb_port_e_pin_function_select;
   import pe_mux_pkg::*;
   logic mclk, rst, s2, mr, e;
   apb_req_s req;
   apb_rsp_s rsp;
   logic [5:0] pi, po, poe, to, toe, p_in, t_in, pd, pdoe, bad, ev;
   logic [31:0] q, d;
   int n_mismatch, n_checks, ctrl_m, cyc;
   port_e_pin_function_select uut (.mclk(mclk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
      .port_out(po), .port_oe(poe), .port_in(p_in), .timer_out(to), .timer_oe(toe),
      .timer_in(t_in), .serial2_transmit(s2), .manual_reset_in(mr), .pad_in(pi),
      .pad_out(pd), .pad_oe(pdoe), .pin_mode_invalid(bad));
   pin_partner far (.mclk(mclk), .pad_in(pi), .port_out(po), .port_oe(poe),
      .timer_out(to), .timer_oe(toe), .serial2_transmit(s2));
   // ----------
   // Tasks
   // ----------
   task automatic check(input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
      input logic [3:0] s);
      @(posedge mclk);
      req <= '{a, 1'b1, 1'b0, w, v, s};
      @(posedge mclk);
      req.penable <= 1'b1;
      do @(posedge mclk); while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   task automatic pins();
      int c;
      logic [5:0] oe, o, ip, it, iv;
      logic m;
      repeat (2) @(negedge mclk);
      m = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         c = (ctrl_m >> (2 * i + 2)) & 3;
         oe[i] = c == 0 ? poe[i] : c == 1 ? toe[i] : (c == 2 && i == 1);
         o[i] = c == 0 ? po[i] : c == 1 ? to[i] : s2;
         ip[i] = c == 0 && pi[i];
         it[i] = c == 1 && pi[i];
         iv[i] = c == 3 || (c == 2 && i != 1 && i != 4);
         if (i == 4 && c == 2) m = pi[4];
      end
      check(pdoe, oe);
      check(pd & oe, o & oe);
      check({p_in, t_in}, {ip, it});
      check({bad, mr}, {iv, m});
      ev = iv;
   endtask : pins
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   // ----------
   // Sequence
   // ----------
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   initial
   begin
      rst = 1'b1;
      req = '0;
      ctrl_m = 0;
      void'($urandom(32'h1621111e));
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, ctrl_offset, 0, 4'h0);
      check(q, 0);
      pins();
      for (int p = 0; p < 6; p++)
         for (int c = 0; c < 4; c++)
         begin
            ctrl_m = c << (2 * p + 2);
            apb(1'b1, ctrl_offset, 32'(ctrl_m), 4'hf);
            pins();
            apb(1'b0, status_offset, 0, 4'h0);
            check(q, {26'h0, ev});
            apb(1'b0, ctrl_offset, 0, 4'h0);
            check(q, ctrl_m);
         end
      apb(1'b0, 12'h008, 0, 4'h0);
      check(e, 1'b1);
      repeat (40)
      begin
         d = $urandom & 32'hffff_c003;
         // Only defined codes from here on
         for (int i = 0; i < 6; i++) d |= ($urandom % ((i == 1 || i == 4) ? 3 : 2)) << (2 * i + 2);
         apb(1'b1, ctrl_offset, d, 4'($urandom));
         if (req.pstrb[0]) ctrl_m = (ctrl_m & 32'hff00) | (d & 32'hfc);
         if (req.pstrb[1]) ctrl_m = (ctrl_m & 32'hff) | (d & 32'h3f00);
         pins();
         apb(1'b0, ctrl_offset, 0, 4'h0);
         check(q, ctrl_m);
      end
      finish_test();
   end
endmodule : tb_port_e_pin_function_select
`default_nettype wire
